// ---- hdl/serial_flash_write_protect.v ----
`timescale 1ns/1ps
`include "flash_wp_regs.vh"

// Notes on behaviour
// - during power-on reset nothing runs and no instruction is taken
// - after reset, write-class instructions rejected for the power-up write delay
// - after power-up the write enable latch reads 0
// - write-class instructions need the write enable latch set first
// - latch clears at power-up and after disable, program, erase, status write
// - in power-down only the release instruction is obeyed
// - busy flag at status bit 0 reads 1 during program, erase, status write
// - while busy only read status is obeyed
// - busy clears when the internal cycle ends
// - latch shown at status bit 1, set by write enable
// - protect range bits at 4:2, non-volatile, written only by status write
// - range and end-select bits held while lock is 1 and protect pin low
// - end-select 0 protects from top, 1 from bottom
// - status bit 6 reads 0
// - lock bit at 7, default 0; then protect pin has no effect
// - lock 1: status write refused while protect pin low, taken when high
// - protected 64KB blocks read-only; 8M codes 1..4 give 1/16..1/2
// - code 0 protects nothing; 1M and 2M ignore the top protect bit
// - write-class instruction ended mid-byte is dropped
// - write disable code clears the latch
// - read status code returns the status word on the output
module serial_flash_write_protect #(
   parameter [1:0]  DENSITY       = `DENS_8M,
   parameter [31:0] TPUW_CYCLES   = `TPUW_CYCLES,
   parameter [31:0] TW_CYCLES     = `TW_CYCLES,
   parameter [31:0] TPP_CYCLES    = `TPP_CYCLES,
   parameter [31:0] TERASE_CYCLES = `TERASE_CYCLES
) (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       spi_cs_n,
   input  wire       spi_clk,
   input  wire       spi_di,
   input  wire       wp_n,
   output reg        spi_do,
   output reg        spi_do_oe_n,
   output reg  [7:0] flash_status_word,
   output reg        array_write_pulse,
   output reg  [23:0] array_write_addr
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   reg [1:0] cs_s_reg, ck_s_reg, di_s_reg, wp_s_reg;
   reg       ck_d_reg;
   always @(posedge clk_sys) begin
      cs_s_reg <= {cs_s_reg[0], spi_cs_n};
      ck_s_reg <= {ck_s_reg[0], spi_clk};
      di_s_reg <= {di_s_reg[0], spi_di};
      wp_s_reg <= {wp_s_reg[0], wp_n};
      ck_d_reg <= ck_s_reg[1];
   end
   wire cs_n    = cs_s_reg[1];
   wire ck_rise = ck_s_reg[1] & ~ck_d_reg & ~cs_n;
   wire ck_fall = ~ck_s_reg[1] & ck_d_reg & ~cs_n;
   wire wp_pin  = wp_s_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // protection decode
   function prot_hit;
      input [1:0]  dens;
      input        tb;
      input [2:0]  bp;
      input [23:0] addr;
      reg   [3:0]  blk;
      reg   [3:0]  nblk;
      reg   [3:0]  top;
      begin
         blk  = addr[19:16];
         top  = 4'h0;
         nblk = 4'h0;
         case (dens)
            `DENS_8M: begin
               top = 4'hF;
               case (bp)
                  3'h0: nblk = 4'h0;
                  3'h1: nblk = 4'h1;
                  3'h2: nblk = 4'h2;
                  3'h3: nblk = 4'h4;
                  3'h4: nblk = 4'h8;
                  default: nblk = 4'hF;
               endcase
            end
            `DENS_4M: begin
               top = 4'h7;
               blk = {1'b0, addr[18:16]};
               if (bp[2]) nblk = 4'h8;
               else nblk = (bp[1:0] == 2'h3) ? 4'h4 : {2'b00, bp[1:0]};
            end
            `DENS_2M: begin
               top = 4'h3;
               blk = {2'b00, addr[17:16]};
               nblk = (bp[1:0] == 2'h3) ? 4'h4 : {2'b00, bp[1:0]};
            end
            default: begin
               top = 4'h1;
               blk = {3'b000, addr[16]};
               nblk = bp[1] ? 4'h2 : {3'b000, bp[0]};
            end
         endcase
         if (nblk == 4'h0) prot_hit = 1'b0;
         else if (nblk > top || nblk == 4'hF) prot_hit = 1'b1;
         else if (tb) prot_hit = (blk < nblk);
         else prot_hit = (blk > (top - nblk));
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state
   localparam [1:0] ST_PUW = 2'h0, ST_IDLE = 2'h1, ST_BUSY = 2'h2, ST_PD = 2'h3;
   reg [1:0]  state_reg, state_next;
   reg [31:0] cnt_reg, cnt_next;
   reg        wel_reg, wel_next;
   reg [7:0]  sh_reg;
   reg [5:0]  bits_reg;
   reg [7:0]  op_reg;
   reg [23:0] addr_reg;
   reg [7:0]  data_reg;
   reg        cs_d_reg;
   reg [7:0]  out_reg;
   reg        st_wr;
   reg [7:0]  st_wdata;
   reg        pend_wr_reg;
   reg [7:0]  pend_data_reg;
   reg        arr_pend_reg;
   wire [7:0] nv_bits;

   status_store u_store (
      .clk_sys (clk_sys),
      .wr_en   (st_wr),
      .wr_data (st_wdata),
      .rd_data (nv_bits)
   );

   wire       busy    = (state_reg == ST_BUSY);
   wire [7:0] sr_view = {nv_bits[7], 1'b0, nv_bits[5:2], wel_reg, busy};
   wire       cs_end  = cs_n & ~cs_d_reg;
   wire       whole   = (bits_reg[2:0] == 3'h0);
   wire [7:0] byte_in = {sh_reg[6:0], di_s_reg[1]};
   wire       locked  = nv_bits[`SR_LOCK_BIT] & ~wp_pin;
   wire       hit     = prot_hit(DENSITY, nv_bits[`SR_TB_BIT], nv_bits[4:2], addr_reg);
   // an empty frame must not replay the previous opcode
   wire       is_cmd  = (state_reg == ST_IDLE) & cs_end & whole & (bits_reg != 6'h00);

   ////////////////////////////////////////////////////////////////////////
   // serial shifter, clocked by sampled edges
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         sh_reg   <= 8'h00;
         bits_reg <= 6'h00;
         op_reg   <= 8'h00;
         addr_reg <= 24'h000000;
         data_reg <= 8'h00;
         cs_d_reg <= 1'b1;
         out_reg  <= 8'h00;
         spi_do   <= 1'b0;
         spi_do_oe_n <= 1'b1;
      end else begin
         cs_d_reg <= cs_n;
         if (cs_n) begin
            bits_reg    <= 6'h00;
            spi_do_oe_n <= 1'b1;
         end else if (ck_rise) begin
            sh_reg <= byte_in;
            if (bits_reg != 6'h3F) bits_reg <= bits_reg + 6'h01;
            if (bits_reg == 6'h07) op_reg <= byte_in;
            if (bits_reg == 6'h0F) data_reg <= byte_in;
            if (bits_reg >= 6'h08 && bits_reg < 6'h20) addr_reg <= {addr_reg[22:0], di_s_reg[1]};
         end else if (ck_fall && op_reg == `OP_READ_STATUS && bits_reg >= 6'h08
                      && bits_reg[2:0] == 3'h0 && state_reg != ST_PD && state_reg != ST_PUW) begin
            spi_do      <= sr_view[7];
            out_reg     <= {sr_view[6:0], sr_view[7]};
            spi_do_oe_n <= 1'b0;
         end else if (ck_fall && op_reg == `OP_READ_STATUS && bits_reg >= 6'h08
                      && state_reg != ST_PD && state_reg != ST_PUW) begin
            spi_do  <= out_reg[7];
            out_reg <= {out_reg[6:0], out_reg[7]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction execution
   always @* begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != 32'h0) ? cnt_reg - 32'h1 : cnt_reg;
      wel_next   = wel_reg;
      st_wr      = 1'b0;
      st_wdata   = nv_bits;
      case (state_reg)
         ST_PUW: begin
            wel_next = 1'b0;
            if (cnt_reg == 32'h0) state_next = ST_IDLE;
         end
         ST_IDLE: begin
            if (is_cmd) begin
               case (op_reg)
                  `OP_WRITE_ENABLE: wel_next = 1'b1;
                  `OP_WRITE_DISABLE: wel_next = 1'b0;
                  `OP_POWER_DOWN: state_next = ST_PD;
                  `OP_WRITE_STATUS: if (wel_reg && bits_reg == 6'h10) begin
                     wel_next = 1'b0;
                     if (!locked) begin
                        state_next = ST_BUSY;
                        cnt_next   = TW_CYCLES;
                     end
                  end
                  `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE:
                     if (wel_reg && bits_reg >= 6'h20) begin
                        wel_next = 1'b0;
                        if (!hit) begin
                           state_next = ST_BUSY;
                           cnt_next = (op_reg == `OP_PAGE_PROGRAM) ? TPP_CYCLES
                                                                   : TERASE_CYCLES;
                        end
                     end
                  `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: if (wel_reg) begin
                     wel_next = 1'b0;
                     if (nv_bits[4:2] == 3'h0 || (DENSITY <= `DENS_2M
                         && nv_bits[3:2] == 2'h0)) begin
                        state_next = ST_BUSY;
                        cnt_next   = TERASE_CYCLES;
                     end
                  end
                  default: state_next = ST_IDLE;
               endcase
            end
         end
         ST_BUSY: begin
            if (cnt_reg == 32'h0) begin
               state_next = ST_IDLE;
               if (pend_wr_reg) begin
                  st_wr    = 1'b1;
                  st_wdata = pend_data_reg & `SR_WRITE_MASK;
               end
            end
         end
         ST_PD: begin
            if (cs_end && op_reg == `OP_RELEASE_PD && bits_reg >= 6'h08) state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg         <= ST_PUW;
         cnt_reg           <= TPUW_CYCLES;
         wel_reg           <= 1'b0;
         pend_wr_reg       <= 1'b0;
         pend_data_reg     <= 8'h00;
         arr_pend_reg      <= 1'b0;
         array_write_pulse <= 1'b0;
         array_write_addr  <= 24'h000000;
         flash_status_word <= `SR_RESET_VALUE;
      end else begin
         state_reg         <= state_next;
         cnt_reg           <= cnt_next;
         wel_reg           <= wel_next;
         flash_status_word <= sr_view;
         array_write_pulse <= 1'b0;
         if (state_reg == ST_IDLE && state_next == ST_BUSY) begin
            pend_wr_reg   <= (op_reg == `OP_WRITE_STATUS);
            pend_data_reg <= data_reg;
            arr_pend_reg  <= (op_reg != `OP_WRITE_STATUS);
            array_write_addr <= addr_reg;
         end else if (state_reg == ST_BUSY && state_next == ST_IDLE) begin
            pend_wr_reg       <= 1'b0;
            arr_pend_reg      <= 1'b0;
            array_write_pulse <= arr_pend_reg;
         end
      end
   end
endmodule // serial_flash_write_protect

// ---- include/flash_wp_regs.vh ----
`ifndef FLASH_WP_REGS_VH
`define FLASH_WP_REGS_VH
// status word bit positions
`define SR_BUSY_BIT      0
`define SR_WEL_BIT       1
`define SR_BP0_BIT       2
`define SR_BP1_BIT       3
`define SR_BP2_BIT       4
`define SR_TB_BIT        5
`define SR_RSVD_BIT      6
`define SR_LOCK_BIT      7
`define SR_RESET_VALUE   8'h00
`define SR_WRITE_MASK    8'hBC
// instruction codes
`define OP_WRITE_ENABLE  8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS   8'h05
`define OP_WRITE_STATUS  8'h01
`define OP_PAGE_PROGRAM  8'h02
`define OP_SECTOR_ERASE  8'h20
`define OP_BLOCK_ERASE   8'hD8
`define OP_CHIP_ERASE_A  8'hC7
`define OP_CHIP_ERASE_B  8'h60
`define OP_POWER_DOWN    8'hB9
`define OP_RELEASE_PD    8'hAB
// density codes
`define DENS_1M          2'h0
`define DENS_2M          2'h1
`define DENS_4M          2'h2
`define DENS_8M          2'h3
// timing, in microseconds, and cycles at 50 MHz
`define CLK_MHZ          50
`define TPUW_US          1000
`define TPUW_CYCLES      (`TPUW_US * `CLK_MHZ)
`define TW_US            1000
`define TW_CYCLES        (`TW_US * `CLK_MHZ)
`define TPP_US           2000
`define TPP_CYCLES       (`TPP_US * `CLK_MHZ)
`define TERASE_US        4000
`define TERASE_CYCLES    (`TERASE_US * `CLK_MHZ)
`endif

// ---- hdl/status_store.v ----
`timescale 1ns/1ps
// small non-volatile status cell model: registered read of stored fields
module status_store (
   input  wire       clk_sys,
   input  wire       wr_en,
   input  wire [7:0] wr_data,
   output reg  [7:0] rd_data
);
   reg [7:0] cell_reg;

   // no reset: contents survive, factory value set once at start
   initial cell_reg = 8'h00;

   always @(posedge clk_sys) begin
      if (wr_en) begin
         cell_reg <= wr_data;
      end
      rd_data <= wr_en ? wr_data : cell_reg;
   end
endmodule // status_store

// ---- bench/flash_wp_chk_asserts.sv ----
`timescale 1ns/1ps
module flash_wp_chk #(
   parameter TPUW_CYCLES   = 400,
   parameter TW_CYCLES     = 300,
   parameter TERASE_CYCLES = 300
) (
   input wire       clk_sys,
   input wire       rst_n,
   input wire       spi_cs_n,
   input wire       spi_do_oe_n,
   input wire [7:0] flash_status_word,
   input wire       array_write_pulse
);
   wire busy = flash_status_word[0];
   wire write_enable_latch  = flash_status_word[1];
   int  up_cnt;
   int  busy_len;
   // counters only; nv bits carry no reset, so compare them with case equality
   always @(posedge clk_sys) begin
      up_cnt   <= !rst_n ? 0 : up_cnt + (up_cnt < TPUW_CYCLES);
      busy_len <= (!rst_n || !busy) ? 0 : busy_len + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   rst_clear_a: assert property (disable iff (1'b0)
      !rst_n [*3] |-> !write_enable_latch && !busy && spi_do_oe_n) else $error("status not clear in reset");
   lockout_wel_a: assert property (up_cnt < TPUW_CYCLES |-> !write_enable_latch)
      else $error("latch set during lockout");
   rsvd_zero_a: assert property (flash_status_word[6] == 1'b0)
      else $error("reserved bit set");
   oe_idle_a: assert property (spi_cs_n [*5] |-> spi_do_oe_n)
      else $error("output driven while deselected");
   wel_first_a: assert property ($rose(busy) |-> $past(write_enable_latch) || $past(write_enable_latch, 2))
      else $error("busy without latch");
   busy_drop_wel_a: assert property ($rose(busy) |-> ##[0:4] !write_enable_latch)
      else $error("latch kept after write");
   busy_len_a: assert property ($fell(busy) |->
      busy_len >= TW_CYCLES - 1 && busy_len <= TERASE_CYCLES + 1) else $error("busy length");
   nv_hold_a: assert property (!busy [*4] |->
      flash_status_word[7:2] === $past(flash_status_word[7:2])) else $error("nv bits moved");
   busy_no_wel_a: assert property (busy |=> !$rose(write_enable_latch))
      else $error("latch set while busy");
   pulse_one_a: assert property (array_write_pulse |=> !array_write_pulse)
      else $error("write pulse too long");
   cover property ($fell(busy));
   cover property (array_write_pulse);
   cover property (write_enable_latch && !spi_do_oe_n);
endmodule // flash_wp_chk
bind serial_flash_write_protect flash_wp_chk #(.TPUW_CYCLES(TPUW_CYCLES),
   .TW_CYCLES(TW_CYCLES), .TERASE_CYCLES(TERASE_CYCLES)) i_flash_wp_chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_do_oe_n(spi_do_oe_n),
   .flash_status_word(flash_status_word), .array_write_pulse(array_write_pulse));

// ---- bench/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
   output logic       spi_cs_n,
   output logic       spi_clk,
   output logic       spi_di,
   input  wire        spi_do,
   output logic [7:0] rx_byte,
   output logic       rx_stb
);
   initial begin
      spi_cs_n = 1'b1;
      spi_clk  = 1'b0;
      spi_di   = 1'b0;
      rx_byte  = 8'h00;
      rx_stb   = 1'b0;
   end
   // mode 0, msb first; clock parked low between frames
   task automatic xfer(input logic [63:0] d, input int n, input logic rd);
      #7 spi_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spi_di = d[i];
         #80 spi_clk = 1'b1;
         rx_byte = {rx_byte[6:0], spi_do};
         #80 spi_clk = 1'b0;
      end
      #80 spi_cs_n = 1'b1;
      spi_di = ~spi_di; // released line must not look valid
      rx_stb = rd;
      #200 rx_stb = 1'b0;
   endtask
endmodule // spi_host_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   localparam TPUW = 400;
   localparam TBSY = 300;
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        wp_n    = 1'b1;
   wire         spi_cs_n, spi_clk, spi_di, spi_do, spi_do_oe_n, array_write_pulse, rx_stb;
   wire  [7:0]  flash_status_word, rx_byte;
   wire  [23:0] array_write_addr;
   logic [15:0] exp_s[$];
   logic [23:0] exp_a[$];
   logic [15:0] q;
   logic [23:0] a;
   logic [7:0]  op, v;
   logic        t;
   int          err_count = 0;
   int          n_tests   = 0;
   always #10 clk_sys = ~clk_sys;
   serial_flash_write_protect #(.TPUW_CYCLES(TPUW), .TW_CYCLES(TBSY), .TPP_CYCLES(TBSY),
      .TERASE_CYCLES(TBSY)) i_serial_flash_write_protect (.clk_sys(clk_sys), .rst_n(rst_n),
      .spi_cs_n(spi_cs_n), .spi_clk(spi_clk), .spi_di(spi_di), .wp_n(wp_n), .spi_do(spi_do),
      .spi_do_oe_n(spi_do_oe_n), .flash_status_word(flash_status_word),
      .array_write_pulse(array_write_pulse), .array_write_addr(array_write_addr));
   spi_host_model i_spi_host_model (.spi_cs_n(spi_cs_n), .spi_clk(spi_clk), .spi_di(spi_di),
      .spi_do(spi_do), .rx_byte(rx_byte), .rx_stb(rx_stb));
   ////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] got, want);
      n_tests++;
      if (got !== want) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", nm, want, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmd(input logic [63:0] d, input int n);
      i_spi_host_model.xfer(d, n, 1'b0);
   endtask
   task automatic rd(input logic [7:0] m, e);
      exp_s.push_back({m, e});
      i_spi_host_model.xfer({8'h05, 8'h00}, 16, 1'b1);
   endtask
   task automatic wait_idle();
      repeat (12) @(posedge clk_sys);
      for (int k = 0; k < 400 && flash_status_word[0] !== 1'b0; k++)
         @(posedge clk_sys);
      if (flash_status_word[0] !== 1'b0) begin
         err_count++;
         final_report();
      end
   endtask
   task automatic wrsr(input logic [7:0] d);
      cmd(8'h06, 8);
      cmd({8'h01, d}, 16);
      wait_idle();
   endtask
   function automatic logic prot(input logic tb, input logic [2:0] c, input logic [23:0] ad);
      int n;
      n = (c == 3'h0) ? 0 : (c > 3'h4) ? 16 : 1 << (c - 1);
      return tb ? ad[19:16] < n : ad[19:16] >= 16 - n;
   endfunction
   always @(posedge rx_stb) begin
      q = exp_s.size() ? exp_s.pop_front() : 16'hXXXX;
      check("status", rx_byte & q[15:8], q[7:0]);
   end
   always @(posedge clk_sys)
      if (array_write_pulse === 1'b1)
         check("wr_addr", array_write_addr, exp_a.size() ? exp_a.pop_front() : 'x);
   ////////////////////////////////////////////////////////////
   initial begin
      v = $urandom(92144);
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      cmd(8'h06, 8);
      repeat (TPUW) @(posedge clk_sys);
      rd(8'h03, 8'h00);
      wrsr(8'h00);
      rd(8'hFF, 8'h00);
      cmd({8'h01, 8'h1C}, 16);
      rd(8'hFF, 8'h00);
      cmd(8'h06, 8);
      rd(8'hFF, 8'h02);
      cmd(8'h04, 8);
      rd(8'hFF, 8'h00);
      cmd(8'h06, 8);
      cmd({8'h01, 8'h0C}, 16);
      cmd(8'h06, 8);
      rd(8'h03, 8'h01);
      wait_idle();
      rd(8'hFF, 8'h0C);
      for (int c = 0; c < 8; c++) begin
         t = $urandom % 2;
         a = $urandom & 32'h000FFFFF;
         op = (c % 3 == 0) ? 8'h02 : (c % 3 == 1) ? 8'h20 : 8'hD8;
         wrsr({2'h0, t, c[2:0], 2'h0});
         if (!prot(t, c[2:0], a))
            exp_a.push_back(a);
         cmd(8'h06, 8);
         if (op == 8'h02)
            cmd({op, a, 8'hA5}, 40);
         else
            cmd({op, a}, 32);
         wait_idle();
         rd(8'hFF, {2'h0, t, c[2:0], 2'h0});
      end
      @(posedge clk_sys) #1 wp_n = 1'b0;
      wrsr(8'h84);
      rd(8'hFF, 8'h84);
      wrsr(8'h3C);
      rd(8'hFF, 8'h84);
      @(posedge clk_sys) #1 wp_n = 1'b1;
      wrsr(8'h00);
      rd(8'hFF, 8'h00);
      cmd(8'h06, 8);
      cmd({8'h01, 4'hC}, 12);
      wait_idle();
      rd(8'hFD, 8'h00);
      cmd(8'h04, 8);
      cmd(8'hB9, 8);
      cmd(8'h06, 8);
      cmd(8'hAB, 8);
      rd(8'hFF, 8'h00);
      repeat (20) @(posedge clk_sys);
      check("pending", exp_s.size() + exp_a.size(), 0);
      final_report();
   end
endmodule // testbench
